// [rtl/ntc_convert.v]
// Function
// RL1: One output type fixed at build time.
// RL2: Fixed output signed or unsigned by choice.
// RL3: Fixed output has width and binary point.
// RL4: Float output single, double or custom widths.
// RL5: Truncate drops bits below output LSB.
// RL6: Symmetric round: ties go away from zero.
// RL7: Convergent round: ties go to even.
// RL8: Saturate clamps to largest or smallest value.
// RL9: Wrap drops bits above output MSB.
// RL10: Flag-error overflow behaves as wrap.
// RL11: Enable low holds all datapath state.
// RL12: Output delayed by configured sample periods.
// RL13: Plain mode puts extra latency after logic.
// RL14: Max pipelining spreads latency inside logic.
// RL15: Plain mode: one output register, rest after.
// RL16: Reset clears pipeline, beats the enable.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ntc_defines.vh"
module ntc_convert #(
  parameter IN_W = 16,
  parameter IN_FRAC = 8,
  parameter IN_SIGNED = 1,
  parameter OUT_TYPE = `NTC_T_FIX,
  parameter OUT_SIGNED = 1,
  parameter OUT_W = 12,
  parameter OUT_FRAC = 4,
  parameter FLT_PREC = `NTC_P_SGL,
  parameter CUST_EXP_W = 6,
  parameter CUST_FRC_W = 17,
  parameter LATENCY = 1,
  parameter PIPE_MAX = 0,
  parameter EXP_W = (FLT_PREC == `NTC_P_SGL) ? `NTC_SGL_EXP_W :
                    (FLT_PREC == `NTC_P_DBL) ? `NTC_DBL_EXP_W : CUST_EXP_W,
  parameter FRC_W = (FLT_PREC == `NTC_P_SGL) ? `NTC_SGL_FRC_W :
                    (FLT_PREC == `NTC_P_DBL) ? `NTC_DBL_FRC_W : CUST_FRC_W,
  parameter DOUT_W = (OUT_TYPE == `NTC_T_FLT) ? (1 + EXP_W + FRC_W) :
                     (OUT_TYPE == `NTC_T_FIX) ? OUT_W : 1
) (
  input wire CLOCK_IN, // 100 MHz clock
  input wire RST_IN, // Synchronous reset, high
  input wire EN_IN, // Datapath enable, high
  input wire [IN_W-1:0] DATA_IN, // Input sample
  input wire VALID_IN, // Input sample present
  output wire [DOUT_W-1:0] DATA_OUT, // Converted sample
  output wire VALID_OUT, // Converted sample present
  input wire PSEL_IN, // APB select
  input wire PENABLE_IN, // APB access phase
  input wire PWRITE_IN, // APB write
  input wire [7:0] PADDR_IN, // APB byte address
  input wire [31:0] PWDATA_IN, // APB write data
  output wire [31:0] PRDATA_OUT, // APB read data
  output wire PREADY_OUT, // APB ready
  output wire PSLVERR_OUT // APB error
);

  // Latency of at least one, since outputs are registered
  localparam LAT = (LATENCY < 1) ? 1 : LATENCY;
  // Stages kept inside the conversion logic
  localparam INT_ST = (PIPE_MAX != 0) ?
                      ((LAT < `NTC_MAX_INT_ST) ? LAT : `NTC_MAX_INT_ST) : 1;
  // Stages left for the tail shift register
  localparam TAIL = LAT - INT_ST;
  // Fraction bits dropped, with two guard bits below
  localparam DROP = IN_FRAC + 2;
  // Working width with room for shifting and rounding
  localparam WW = IN_W + OUT_FRAC + OUT_W + 4;
  // Float width and exponent bias
  localparam FLT_W = 1 + EXP_W + FRC_W;
  localparam BIAS = (1 << (EXP_W - 1)) - 1;
  // Build-time facts shown to software
  localparam [7:0] LAT_B = LAT;
  localparam [1:0] TYPE_B = OUT_TYPE;

  // Mapped register decode, used by read and write
  function ntc_mapped;
    input [7:0] addr;
    begin
      ntc_mapped = (addr == `NTC_CTRL_OFS) || (addr == `NTC_STAT_OFS) ||
                   (addr == `NTC_COUNT_OFS) || (addr == `NTC_CONF_OFS);
    end
  endfunction

  // Index of the highest set bit, zero for zero
  function integer ntc_lead;
    input [IN_W-1:0] v;
    integer i;
    begin
      ntc_lead = 0;
      for (i = 0; i < IN_W; i = i + 1) begin
        if (v[i]) begin
          ntc_lead = i;
        end
      end
    end
  endfunction

  reg [1:0] qnt_q; // Quantization mode
  reg [1:0] ovf_q; // Overflow mode
  reg ovf_seen_q; // Sticky overflow seen
  reg [31:0] count_q; // Conversions done
  reg pready_q; // Ready for access phase
  reg pslverr_q; // Error for access phase
  reg [31:0] prdata_q; // Read data for access phase
  reg [DOUT_W-1:0] out_q; // Conversion output register
  reg vld_q; // Output register holds a sample

  // Stage 0: align and round

  wire in_neg = (IN_SIGNED != 0) & DATA_IN[IN_W-1]; // Input sign
  wire [WW-1:0] ext_w = {{(WW-IN_W){in_neg}}, DATA_IN}; // Extended input
  // Scale so the output LSB sits just above DROP bits
  wire [WW-1:0] scl_w = ext_w << (OUT_FRAC + 2);
  // Kept part, floor of the value
  wire signed [WW-1:0] kept_w = $signed(scl_w) >>> DROP; // RL3
  wire [DROP-1:0] frc_w = scl_w[DROP-1:0]; // Bits below output LSB
  wire above_w = frc_w[DROP-1] & (|frc_w[DROP-2:0]); // Past midpoint
  wire tie_w = frc_w[DROP-1] & ~(|frc_w[DROP-2:0]); // Exact midpoint
  reg inc_w; // Round up by one LSB

  // Rounding decision per quantization mode
  always @* begin
    case (qnt_q)
      `NTC_Q_SYM: begin
        // Floor already moves negative ties away from zero
        inc_w = above_w | (tie_w & ~kept_w[WW-1]); // RL6
      end
      `NTC_Q_CONV: begin
        // Tie goes up only when kept LSB is odd
        inc_w = above_w | (tie_w & kept_w[0]); // RL7
      end
      default: begin
        // Low bits simply dropped
        inc_w = 1'b0; // RL5
      end
    endcase
  end

  wire [WW-1:0] rnd_w = kept_w + {{(WW-1){1'b0}}, inc_w}; // Rounded value

  // Float form from magnitude and leading one
  wire [IN_W-1:0] mag_w = in_neg ? (~DATA_IN + 1'b1) : DATA_IN; // Magnitude
  wire [31:0] lead_w = ntc_lead(mag_w); // Leading one index
  wire [IN_W-1:0] norm_w = mag_w << (IN_W - 1 - lead_w); // Leading one at top
  wire [IN_W-2+FRC_W:0] mwide_w = {norm_w[IN_W-2:0], {FRC_W{1'b0}}}; // Fraction
  wire [31:0] exp_w = lead_w - IN_FRAC + BIAS; // Biased exponent
  wire [FLT_W-1:0] flt_w = (mag_w == {IN_W{1'b0}}) ? {FLT_W{1'b0}} :
                           {in_neg, exp_w[EXP_W-1:0], mwide_w[IN_W-2+FRC_W -: FRC_W]}; // RL4
  wire bool_w = |DATA_IN; // Nonzero means true

  // Stage 1: optional inner register

  wire [WW-1:0] s1_rnd; // Rounded value after stage 1
  wire [FLT_W-1:0] s1_flt; // Float after stage 1
  wire s1_bool; // Boolean after stage 1
  wire s1_vld; // Valid after stage 1

  generate
    if (INT_ST == `NTC_MAX_INT_ST) begin : g_inner
      reg [WW-1:0] rnd_q; // Held rounded value
      reg [FLT_W-1:0] flt_q; // Held float
      reg bool_q; // Held Boolean
      reg v_q; // Held valid
      // Inner stage, part of the configured latency
      always @(posedge CLOCK_IN) begin
        if (RST_IN) begin
          rnd_q <= {WW{1'b0}}; // RL16
          flt_q <= {FLT_W{1'b0}};
          bool_q <= 1'b0;
          v_q <= 1'b0;
        end else if (EN_IN) begin
          rnd_q <= rnd_w; // RL14
          flt_q <= flt_w;
          bool_q <= bool_w;
          v_q <= VALID_IN;
        end
      end
      assign s1_rnd = rnd_q;
      assign s1_flt = flt_q;
      assign s1_bool = bool_q;
      assign s1_vld = v_q;
    end else begin : g_flat
      // No inner stage
      assign s1_rnd = rnd_w;
      assign s1_flt = flt_w;
      assign s1_bool = bool_w;
      assign s1_vld = VALID_IN;
    end
  endgenerate

  // Stage 2: range check and clamp

  wire r_neg = s1_rnd[WW-1]; // Sign of rounded value
  wire [WW-OUT_W:0] s_hi = s1_rnd[WW-1:OUT_W-1]; // Sign-copy span
  // Out of range for the chosen arithmetic
  wire ovf_w = (OUT_SIGNED != 0) ? ~((&s_hi) | ~(|s_hi)) : (|s1_rnd[WW-1:OUT_W]); // RL2
  // Clamp values for each arithmetic
  wire [OUT_W-1:0] smax_w = (OUT_SIGNED != 0) ? {1'b0, {(OUT_W-1){1'b1}}} : {OUT_W{1'b1}};
  wire [OUT_W-1:0] smin_w = (OUT_SIGNED != 0) ? {1'b1, {(OUT_W-1){1'b0}}} : {OUT_W{1'b0}};
  reg [OUT_W-1:0] fix_w; // Fixed result

  // Overflow handling per mode
  always @* begin
    case (ovf_q)
      `NTC_O_SAT: begin
        // Clamp toward the side that overflowed
        fix_w = ovf_w ? (r_neg ? smin_w : smax_w) : s1_rnd[OUT_W-1:0]; // RL8
      end
      `NTC_O_FLAG: begin
        // Same hardware as wrap
        fix_w = s1_rnd[OUT_W-1:0]; // RL10
      end
      default: begin
        // Upper bits discarded
        fix_w = s1_rnd[OUT_W-1:0]; // RL9
      end
    endcase
  end

  // Pick the build-time output type
  wire [DOUT_W-1:0] res_w; // Result for output register
  generate
    if (OUT_TYPE == `NTC_T_FLT) begin : g_flt
      assign res_w = s1_flt; // RL1
    end else if (OUT_TYPE == `NTC_T_FIX) begin : g_fix
      assign res_w = fix_w; // RL1
    end else begin : g_bool
      assign res_w = s1_bool; // RL1
    end
  endgenerate

  // Overflow only exists for fixed output
  wire ovf_evt = (OUT_TYPE == `NTC_T_FIX) && EN_IN && s1_vld && ovf_w;

  // Output register at the conversion output
  always @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      out_q <= {DOUT_W{1'b0}}; // RL16
      vld_q <= 1'b0;
    end else if (EN_IN) begin
      out_q <= res_w; // RL15
      vld_q <= s1_vld; // RL12
    end
  end

  // Remaining latency as a tail shift register
  wire [DOUT_W:0] tail_w; // Tail output, valid on top
  ntc_delay #(
    .W(DOUT_W + 1),
    .DEPTH(TAIL)
  ) u_tail (
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .en_in(EN_IN), // RL11
    .din_in({vld_q, out_q}), // RL13
    .dout_out(tail_w)
  );
  assign DATA_OUT = tail_w[DOUT_W-1:0];
  assign VALID_OUT = tail_w[DOUT_W];

  // APB slave

  wire setup_w = PSEL_IN & ~PENABLE_IN; // Setup phase
  wire wr_w = PSEL_IN & PENABLE_IN & pready_q & PWRITE_IN; // Write completes
  wire hit_w = ntc_mapped(PADDR_IN); // Address decodes
  wire wr_ctrl = wr_w & hit_w & (PADDR_IN == `NTC_CTRL_OFS); // Control write
  wire wr_stat = wr_w & hit_w & (PADDR_IN == `NTC_STAT_OFS); // Status write
  reg [31:0] rd_w; // Read mux

  // Read mux of the four registers
  always @* begin
    rd_w = `NTC_DATA_RST;
    case (PADDR_IN)
      `NTC_CTRL_OFS: begin
        rd_w[`NTC_CTRL_QNT_LSB +: 2] = qnt_q;
        rd_w[`NTC_CTRL_OVF_LSB +: 2] = ovf_q;
      end
      `NTC_STAT_OFS: begin
        rd_w[`NTC_STAT_OVF_BIT] = ovf_seen_q;
      end
      `NTC_COUNT_OFS: begin
        rd_w = count_q;
      end
      `NTC_CONF_OFS: begin
        rd_w[`NTC_CONF_TYPE_LSB +: 2] = TYPE_B;
        rd_w[`NTC_CONF_SGN_BIT] = (OUT_SIGNED != 0);
        rd_w[`NTC_CONF_PIPE_BIT] = (PIPE_MAX != 0);
        rd_w[`NTC_CONF_LAT_LSB +: 8] = LAT_B;
      end
      default: begin
        // Unmapped reads as zero
        rd_w = `NTC_DATA_RST;
      end
    endcase
  end

  // Answer prepared in setup, shown in the access phase
  always @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `NTC_DATA_RST;
    end else begin
      pready_q <= setup_w;
      pslverr_q <= setup_w & ~hit_w;
      prdata_q <= setup_w ? rd_w : `NTC_DATA_RST;
    end
  end

  // Mode register written by software
  always @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      qnt_q <= `NTC_QNT_RST;
      ovf_q <= `NTC_OVF_RST;
    end else if (wr_ctrl) begin
      qnt_q <= PWDATA_IN[`NTC_CTRL_QNT_LSB +: 2];
      ovf_q <= PWDATA_IN[`NTC_CTRL_OVF_LSB +: 2];
    end
  end

  // Sticky overflow, write one to clear, new event wins
  always @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      ovf_seen_q <= 1'b0;
    end else if (ovf_evt) begin
      ovf_seen_q <= 1'b1;
    end else if (wr_stat & PWDATA_IN[`NTC_STAT_OVF_BIT]) begin
      ovf_seen_q <= 1'b0;
    end
  end

  // Conversions taken into the output register
  always @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      count_q <= `NTC_DATA_RST;
    end else if (EN_IN & s1_vld) begin
      count_q <= count_q + 32'h00000001;
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;

endmodule // ntc_convert
`default_nettype wire

// [rtl/ntc_defines.vh]
`ifndef NTC_DEFINES_VH
`define NTC_DEFINES_VH
// Register byte offsets on the APB
`define NTC_CTRL_OFS 8'h00
`define NTC_STAT_OFS 8'h04
`define NTC_COUNT_OFS 8'h08
`define NTC_CONF_OFS 8'h0C
// Control register field positions
`define NTC_CTRL_QNT_LSB 0
`define NTC_CTRL_OVF_LSB 2
// Status register field position
`define NTC_STAT_OVF_BIT 0
// Configuration register field positions
`define NTC_CONF_TYPE_LSB 0
`define NTC_CONF_SGN_BIT 2
`define NTC_CONF_PIPE_BIT 3
`define NTC_CONF_LAT_LSB 8
// Reset values
`define NTC_QNT_RST 2'h0
`define NTC_OVF_RST 2'h0
`define NTC_DATA_RST 32'h00000000
// Quantization mode codes
`define NTC_Q_TRUNC 2'h0
`define NTC_Q_SYM 2'h1
`define NTC_Q_CONV 2'h2
// Overflow mode codes
`define NTC_O_WRAP 2'h0
`define NTC_O_SAT 2'h1
`define NTC_O_FLAG 2'h2
// Output type codes (build time)
`define NTC_T_BOOL 0
`define NTC_T_FIX 1
`define NTC_T_FLT 2
// Float precision codes and widths
`define NTC_P_SGL 0
`define NTC_P_DBL 1
`define NTC_P_CUST 2
`define NTC_SGL_EXP_W 8
`define NTC_SGL_FRC_W 23
`define NTC_DBL_EXP_W 11
`define NTC_DBL_FRC_W 52
// Most stages the conversion logic can hold
`define NTC_MAX_INT_ST 2
`endif

// [rtl/ntc_delay.v]
`timescale 1ns/1ns
`default_nettype none
// Enabled shift register of DEPTH words; DEPTH 0 passes through
module ntc_delay #(
  parameter W = 8,
  parameter DEPTH = 0
) (
  input wire clk_in, // Clock
  input wire rst_in, // Synchronous reset, high
  input wire en_in, // Advance enable
  input wire [W-1:0] din_in, // Word in
  output wire [W-1:0] dout_out // Word out
);
  generate
    if (DEPTH == 0) begin : g_pass
      // No extra stages
      assign dout_out = din_in;
    end else begin : g_line
      reg [W*DEPTH-1:0] sr_q; // Stage storage, newest low
      wire [W*(DEPTH+1)-1:0] nxt_d = {sr_q, din_in}; // Shifted view
      // Shift one word per enabled edge, reset first
      always @(posedge clk_in) begin
        if (rst_in) begin
          sr_q <= {(W*DEPTH){1'b0}}; // RL16
        end else if (en_in) begin
          sr_q <= nxt_d[W*DEPTH-1:0]; // RL13
        end
      end
      // Oldest word leaves
      assign dout_out = sr_q[W*DEPTH-1 -: W];
    end
  endgenerate
endmodule // ntc_delay
`default_nettype wire

// [verification/ntc_convert_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
// Port checker for the converter, bound into its top module
module ntc_convert_monitor #(
  parameter DOUT_W = 12, // Output word width
  parameter LAT = 1 // Effective latency in sample periods
) (
  input wire logic CLOCK_IN, // Clock
  input wire logic RST_IN, // Reset, high
  input wire logic EN_IN, // Enable
  input wire logic VALID_IN, // Sample in
  input wire logic [DOUT_W-1:0] DATA_OUT, // Result
  input wire logic VALID_OUT, // Result present
  input wire logic PSEL_IN, // Select
  input wire logic PENABLE_IN, // Access phase
  input wire logic [7:0] PADDR_IN, // Address
  input wire logic [31:0] PRDATA_OUT, // Read data
  input wire logic PREADY_OUT, // Ready
  input wire logic PSLVERR_OUT // Error
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  // Sample marks over the last LAT enabled edges, oldest on top
  logic [LAT-1:0] vhist_q;
  always @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      vhist_q <= '0;
    end else if (EN_IN) begin
      vhist_q <= (vhist_q << 1) | LAT'(VALID_IN);
    end
  end
  // Bus answer timing
  ready_after_setup_a: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
    else $error("no ready after setup");
  ready_single_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held too long");
  ready_cause_a: assert property ($rose(PREADY_OUT) |-> $past(PSEL_IN) && !$past(PENABLE_IN))
    else $error("ready without setup");
  bus_quiet_a: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h00000000 && !PSLVERR_OUT)
    else $error("bus outputs not quiet");
  misalign_err_a: assert property (PSEL_IN && !PENABLE_IN && PADDR_IN[1:0] != 2'h0
    |=> PSLVERR_OUT && PRDATA_OUT == 32'h00000000)
    else $error("misaligned access not refused");
  // Stream behaviour
  reset_clear_a: assert property ($fell(RST_IN) |-> DATA_OUT == '0 && !VALID_OUT)
    else $error("outputs not cleared by reset");
  enable_hold_a: assert property (!EN_IN && !RST_IN |=> $stable(DATA_OUT) && $stable(VALID_OUT))
    else $error("state moved while disabled");
  valid_delay_a: assert property (VALID_OUT == vhist_q[LAT-1])
    else $error("valid not delayed by the latency");
endmodule // ntc_convert_monitor
bind ntc_convert ntc_convert_monitor #(.DOUT_W(DOUT_W), .LAT(LAT)) mon_u (.CLOCK_IN, .RST_IN, .EN_IN, .VALID_IN,
  .DATA_OUT, .VALID_OUT, .PSEL_IN, .PENABLE_IN, .PADDR_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT);
`default_nettype wire

// [verification/ntc_src_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Upstream sample source: one-cycle samples on request
module ntc_src_model (
  input wire logic clk_in, // Clock
  input wire logic push_in, // Present a sample next cycle
  input wire logic [15:0] val_in, // Sample value
  output logic [15:0] data_out, // Sample lines
  output logic valid_out // Sample present
);
  initial data_out = 16'h5A5A; // Idle pattern seed
  initial valid_out = 1'b0; // Nothing offered yet
  // Idle lines toggle so a stale word never looks held
  always @(posedge clk_in) begin
    valid_out <= push_in;
    data_out <= push_in ? val_in : ~data_out;
  end
endmodule // ntc_src_model
`default_nettype wire

// [verification/numeric_type_converter_bench.sv]
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench: 16-bit Q8 signed in, 10-bit Q4 signed out
module numeric_type_converter_bench;
  logic clk, rst, en, push, vin, vout, psel, penable, pwrite, pready, pslverr;
  logic [15:0] val, din;
  logic [9:0] dout;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [31:0] prdata_p, prdata_f, rp, rf, fout; // Pipelined unsigned and float copies
  logic [9:0] dout_p; // Pipelined copy result
  logic vout_p; // Pipelined copy result present
  logic e;
  int fail_count = 0;
  int tests_run = 0;
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  ntc_src_model src_u (.clk_in(clk), .push_in(push), .val_in(val), .data_out(din), .valid_out(vin));
  ntc_convert #(.OUT_W(10), .OUT_FRAC(4)) dut_u (.CLOCK_IN(clk), .RST_IN(rst), .EN_IN(en),
    .DATA_IN(din), .VALID_IN(vin), .DATA_OUT(dout), .VALID_OUT(vout), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
  // Unsigned copy, latency 4 spread inside the logic and a tail
  ntc_convert #(.OUT_W(10), .OUT_FRAC(4), .OUT_SIGNED(0), .LATENCY(4), .PIPE_MAX(1)) dut_p_u (.CLOCK_IN(clk),
    .RST_IN(rst), .EN_IN(en), .DATA_IN(din), .VALID_IN(vin), .DATA_OUT(dout_p), .VALID_OUT(vout_p),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata_p), .PREADY_OUT(), .PSLVERR_OUT());
  // Single precision float copy
  ntc_convert #(.OUT_TYPE(2)) dut_f_u (.CLOCK_IN(clk), .RST_IN(rst), .EN_IN(en), .DATA_IN(din),
    .VALID_IN(vin), .DATA_OUT(fout), .VALID_OUT(), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata_f), .PREADY_OUT(),
    .PSLVERR_OUT());
  // Verdict and end of run
  task complete_run;
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus transfer, waiting for ready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        chk(32'h0, 32'h1);
        complete_run;
      end
      @(posedge clk);
    end
    r = prdata;
    rp = prdata_p;
    rf = prdata_f;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // Sample through the source, result one enabled edge later
  task automatic send(input logic [15:0] v);
    @(posedge clk); push <= 1; val <= v;
    @(posedge clk); push <= 0;
    @(posedge clk); #1;
    chk(vout, 1);
  endtask
  // Expected {overflow, result}
  function automatic logic [10:0] model(input logic [15:0] d, input logic [1:0] q, input logic [1:0] o);
    logic signed [12:0] b;
    logic ov;
    b = $signed(d[15:4]);
    if ((q == 2'h1 || q == 2'h2) && (d[3:0] > 4'h8 || d[3:0] == 4'h8 && (q == 2'h1 ? !d[15] : b[0])))
      b = b + 13'h0001;
    ov = b > 13'sh01FF || b < 13'sh1E00;
    if (o == 2'h1 && ov) b = d[15] ? 13'sh1E00 : 13'sh01FF;
    return {ov, b[9:0]};
  endfunction
  // Reset values, read-only and unmapped places
  task automatic t_regs;
    apb(0, 8'h00, 0);
    chk(r, 32'h0);
    chk(e, 0);
    apb(0, 8'h08, 0);
    chk(r, 32'h0);
    apb(1, 8'h0C, 32'hFFFFFFFF);
    chk(e, 0);
    apb(0, 8'h0C, 0);
    chk(r, 32'h00000105);
    chk(rp, 32'h00000409);
    chk(rf, 32'h00000106);
    apb(0, 8'h10, 0);
    chk(r, 32'h0);
    chk(e, 1);
    apb(1, 8'h02, 32'h1);
    chk(e, 1);
    apb(0, 8'h00, 0);
    chk(r, 32'h0);
  endtask
  // Every quantization and overflow code over midpoints and overflows
  task automatic t_modes;
    logic [15:0] tv [0:7];
    logic [10:0] ex;
    tv = '{16'h0168, 16'h0018, 16'h0028, 16'hFFE8, 16'hFFEC, 16'h1FF8, 16'h4000, 16'hC000};
    for (int m = 0; m < 16; m++) begin
      apb(1, 8'h00, {28'h0, m[3:0]});
      for (int i = 0; i < 8; i++) begin
        ex = model(tv[i], m[1:0], m[3:2]);
        send(tv[i]);
        chk(dout, ex[9:0]);
        apb(0, 8'h04, 0); chk(r, ex[10]);
        apb(1, 8'h04, 32'h1);
      end
    end
  endtask
  // Enable low freezes, reset wins over enable, count restarts
  task automatic t_hold;
    send(16'h0123);
    en <= 0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk); push <= i[0]; val <= 16'h0777;
      #1 chk({vout, dout}, 11'h412);
    end
    @(posedge clk); push <= 0; rst <= 1;
    @(posedge clk); rst <= 0;
    #1 chk({vout, dout}, 11'h000);
    en <= 1;
    repeat (3) send(16'h0010);
    chk(dout, 10'h001);
    apb(0, 8'h08, 0); chk(r, 32'h3);
    apb(0, 8'h00, 0); chk(r, 32'h0);
  endtask
  // Pipelined unsigned copy and float copy on the same samples
  task automatic t_pipe;
    apb(1, 8'h00, 32'h4);
    send(16'h0168);
    chk(fout, 32'h3FB40000);
    chk(vout_p, 0);
    send(16'hFFE8);
    chk(fout, 32'hBDC00000);
    chk({vout_p, dout_p}, 11'h416);
    @(posedge clk);
    #1 chk(vout_p, 0);
    repeat (2) @(posedge clk);
    #1 chk({vout_p, dout_p}, 11'h400);
  endtask
  initial begin
    rst = 1; en = 1; push = 0; val = 16'h0000;
    psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 0;
    t_regs;
    t_modes;
    t_hold;
    t_pipe;
    complete_run;
  end
endmodule // numeric_type_converter_bench
`default_nettype wire
